//--- core/urm_channel.sv
/*
 * One UART channel register window with internal loopback.
 * Serial framing is outside: the shifter pins are ports.
 * Assumes host strobes are synchronous single-cycle pulses on clk.
 */
// Behaviour
// - Loopback follows modem control bit 4
// - Channel functions unchanged during loopback
// - Transmit shifter output feeds receive shifter
// - Loopback holds tx, rts, dtr pins fixed
// - Loopback ignores modem input pins
// - Auto rts/cts flow disabled in loopback
// - Per-channel registers, active-low channel selects
// - Address 0 reads rx, writes tx
// - Divisor access maps divisor low/high bytes
// - Fractional divisor needs divisor access, ext bit
// - Zero divisor reads give revision, identification
// - Interrupt enable at address 1
// - Address 2 reads status, writes fifo control
// - Fifo control bit fields
// - Line control at address 3
// - Modem control, line, modem status map
// - Scratch register at address 7
// - Unlock value shows enhanced registers
// - Extended bits need enhanced bit 4
// - Bit 4 unlocks modem 7:5, fraction
`timescale 1ns/1ps
module urm_channel
    import urm_pkg::*;
#(
    parameter logic [7:0] REV_CODE = REV_CODE_DEF,
    parameter logic [7:0] ID_CODE  = ID_CODE_DEF
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire urm_bus_t      bus,
    output logic [7:0]         rdata,
    output logic               tx_valid,
    input  wire logic          tx_ready,
    output logic [7:0]         tx_data,
    input  wire logic [7:0]    rx_data,
    input  wire logic          rx_valid,
    output logic               rx_ready,
    input  wire logic [7:0]    line_status,
    input  wire logic [5:0]    int_source,
    input  wire logic          tsr_out,
    input  wire logic          rx_pin,
    output logic               tsr_in,
    output logic               tx_pin,
    output logic               rts_n,
    output logic               dtr_n,
    input  wire urm_modem_in_t modem_in,
    output logic [7:0]         ctl_line,
    output logic [7:0]         ctl_fifo,
    output logic [15:0]        ctl_div,
    output logic [7:0]         ctl_frac,
    output logic               auto_rts_en,
    output logic               auto_cts_en
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] div_lo_reg, div_hi_reg, frac_reg, ien_reg, fctl_reg, lctl_reg;
    logic [7:0] mctl_reg, scr_reg, enh_reg;
    logic [7:0] xon1_reg, xon2_reg, xoff1_reg, xoff2_reg;
    logic [7:0] mstat_reg;
    urm_modem_in_t modem_last_reg;
    urm_bank_t  bank;
    logic       ext_on;
    logic       loop_on;
    logic       wr_hold;
    logic [7:0] ext_mask_ien;
    logic       fifo_in_ready;
    logic [3:0] modem_lvl;

    function automatic logic [7:0] ext_gate(input logic [7:0] v, input logic [7:0] m,
                                            input logic en);
        ext_gate = en ? v : (v & ~m);
    endfunction

    assign ext_on  = enh_reg[ENH_EXT_BIT];
    assign loop_on = mctl_reg[MDM_LOOP_BIT];

    always_comb begin
        if (lctl_reg == LINE_UNLOCK) begin
            bank = BANK_ENH;
        end else if (lctl_reg[LINE_DIV_BIT]) begin
            bank = BANK_DIVISOR;
        end else begin
            bank = BANK_NORMAL;
        end
    end

    // ------------------------------------------------------------
    // Writes
    // ------------------------------------------------------------
    assign wr_hold = bus.wr && bus.addr == OFS_HOLD && bank == BANK_NORMAL;
    assign ext_mask_ien = IEN_EXT_MASK;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_lo_reg <= RST_DIV;
            div_hi_reg <= RST_BYTE;
            frac_reg   <= RST_BYTE;
        end else if (bus.wr && bank == BANK_DIVISOR) begin
            case (bus.addr)
                OFS_HOLD:  div_lo_reg <= bus.wdata;
                OFS_IEN:   div_hi_reg <= bus.wdata;
                OFS_ISTAT: begin
                    if (ext_on) begin
                        frac_reg <= bus.wdata & FRAC_MASK;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ien_reg <= RST_BYTE;
        end else if (bus.wr && bank == BANK_NORMAL && bus.addr == OFS_IEN) begin
            ien_reg <= ext_gate(bus.wdata, ext_mask_ien, ext_on);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fctl_reg <= RST_BYTE;
        end else if (bus.wr && bank != BANK_ENH && bus.addr == OFS_ISTAT
                     && bank == BANK_NORMAL) begin
            fctl_reg <= ext_gate(bus.wdata, FCT_EXT_MASK, ext_on);
        end else begin
            fctl_reg[2:1] <= 2'b00;  // FIFO resets are self-clearing
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lctl_reg <= RST_BYTE;
            mctl_reg <= RST_BYTE;
            scr_reg  <= RST_BYTE;
        end else if (bus.wr) begin
            case (bus.addr)
                OFS_LCTL:    lctl_reg <= bus.wdata;
                OFS_MCTL: begin
                    if (bank != BANK_ENH) begin
                        mctl_reg <= ext_gate(bus.wdata, MDM_EXT_MASK, ext_on);
                    end
                end
                OFS_SCRATCH: begin
                    if (bank != BANK_ENH) begin
                        scr_reg <= bus.wdata;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enh_reg   <= RST_BYTE;
            xon1_reg  <= RST_BYTE;
            xon2_reg  <= RST_BYTE;
            xoff1_reg <= RST_BYTE;
            xoff2_reg <= RST_BYTE;
        end else if (bus.wr && bank == BANK_ENH) begin
            case (bus.addr)
                OFS_ISTAT:   enh_reg   <= bus.wdata;
                OFS_MCTL:    xon1_reg  <= bus.wdata;
                OFS_LSTAT:   xon2_reg  <= bus.wdata;
                OFS_MSTAT:   xoff1_reg <= bus.wdata;
                OFS_SCRATCH: xoff2_reg <= bus.wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Modem status: loopback takes inputs from control bits
    // ------------------------------------------------------------
    always_comb begin
        if (loop_on) begin
            // Ignore pins; echo modem control outputs instead
            modem_lvl = {mctl_reg[MDM_RTS_BIT], mctl_reg[MDM_DTR_BIT],
                         mctl_reg[3], mctl_reg[2]};
        end else begin
            modem_lvl = ~{modem_in.cts_n, modem_in.dsr_n,
                          modem_in.carrier_in_n, modem_in.ring_in_n};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modem_last_reg <= '1;
            mstat_reg      <= RST_BYTE;
        end else begin
            modem_last_reg <= ~modem_lvl;
            // Deltas: change sets, a status read clears; set wins
            mstat_reg[7:4] <= {modem_lvl[1], modem_lvl[0], modem_lvl[2], modem_lvl[3]};
            mstat_reg[3:0] <= ((bus.rd && bank != BANK_ENH && bus.addr == OFS_MSTAT)
                               ? 4'h0 : mstat_reg[3:0])
                            | {modem_last_reg.carrier_in_n ^ ~modem_lvl[1],
                               modem_last_reg.ring_in_n ^ ~modem_lvl[0],
                               modem_last_reg.dsr_n ^ ~modem_lvl[2],
                               modem_last_reg.cts_n ^ ~modem_lvl[3]};
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= ZERO_BYTE;
        end else if (bus.rd) begin
            case (bus.addr)
                OFS_HOLD: begin
                    if (bank == BANK_NORMAL) begin
                        rdata <= rx_data;
                    end else if (div_lo_reg == ZERO_BYTE && div_hi_reg == ZERO_BYTE) begin
                        rdata <= REV_CODE;
                    end else begin
                        rdata <= div_lo_reg;
                    end
                end
                OFS_IEN: begin
                    if (bank == BANK_NORMAL) begin
                        rdata <= ext_gate(ien_reg, IEN_EXT_MASK, ext_on);
                    end else if (div_lo_reg == ZERO_BYTE && div_hi_reg == ZERO_BYTE) begin
                        rdata <= ID_CODE;
                    end else begin
                        rdata <= div_hi_reg;
                    end
                end
                OFS_ISTAT: begin
                    if (bank == BANK_ENH) begin
                        rdata <= enh_reg;
                    end else if (bank == BANK_DIVISOR && ext_on) begin
                        rdata <= frac_reg;
                    end else begin
                        rdata <= ext_gate({{2{fctl_reg[0]}}, int_source},
                                          IST_EXT_MASK, ext_on);
                    end
                end
                OFS_LCTL:    rdata <= lctl_reg;
                OFS_MCTL:    rdata <= (bank == BANK_ENH) ? xon1_reg
                                      : ext_gate(mctl_reg, MDM_EXT_MASK, ext_on);
                OFS_LSTAT:   rdata <= (bank == BANK_ENH) ? xon2_reg : line_status;
                OFS_MSTAT:   rdata <= (bank == BANK_ENH) ? xoff1_reg : mstat_reg;
                OFS_SCRATCH: rdata <= (bank == BANK_ENH) ? xoff2_reg : scr_reg;
                default:     rdata <= ZERO_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transmit holding FIFO; full drops further host writes
    // ------------------------------------------------------------
    urm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
        .clk       (clk),
        .rst_n     (rst_n),
        .flush     (fctl_reg[2]),
        .in_data   (bus.wdata),
        .in_valid  (wr_hold),
        .in_ready  (fifo_in_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // Receive side pops on a holding read; same in loopback
    assign rx_ready = bus.rd && bus.addr == OFS_HOLD && bank == BANK_NORMAL && rx_valid;

    // ------------------------------------------------------------
    // Pins and loopback routing
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tsr_in <= 1'b1;
            tx_pin <= 1'b1;
            rts_n  <= 1'b1;
            dtr_n  <= 1'b1;
        end else begin
            tsr_in <= loop_on ? tsr_out : rx_pin;
            tx_pin <= loop_on ? 1'b1 : tsr_out;
            rts_n  <= loop_on ? 1'b1 : ~mctl_reg[MDM_RTS_BIT];
            dtr_n  <= loop_on ? 1'b1 : ~mctl_reg[MDM_DTR_BIT];
        end
    end

    assign ctl_line    = lctl_reg;
    assign ctl_fifo    = fctl_reg;
    assign ctl_div     = {div_hi_reg, div_lo_reg};
    assign ctl_frac    = ext_on ? frac_reg : ZERO_BYTE;
    assign auto_rts_en = enh_reg[6] && !loop_on;
    assign auto_cts_en = enh_reg[7] && !loop_on;
endmodule

//--- pkg/urm_pkg.sv
/*
 * Package for the UART register window and loopback block.
 * Assumes a host bus with 3 address lines, 8-bit data and one select per channel.
 */
package urm_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] OFS_HOLD    = 3'h0;
    localparam logic [2:0] OFS_IEN     = 3'h1;
    localparam logic [2:0] OFS_ISTAT   = 3'h2;
    localparam logic [2:0] OFS_LCTL    = 3'h3;
    localparam logic [2:0] OFS_MCTL    = 3'h4;
    localparam logic [2:0] OFS_LSTAT   = 3'h5;
    localparam logic [2:0] OFS_MSTAT   = 3'h6;
    localparam logic [2:0] OFS_SCRATCH = 3'h7;
    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam logic [7:0] LINE_UNLOCK  = 8'hBF;
    localparam int         LINE_DIV_BIT = 7;
    localparam int         ENH_EXT_BIT  = 4;
    localparam int         MDM_LOOP_BIT = 4;
    localparam int         MDM_RTS_BIT  = 1;
    localparam int         MDM_DTR_BIT  = 0;
    localparam logic [7:0] IEN_EXT_MASK = 8'hF0;
    localparam logic [7:0] IST_EXT_MASK = 8'h30;
    localparam logic [7:0] FCT_EXT_MASK = 8'h30;
    localparam logic [7:0] MDM_EXT_MASK = 8'hE0;
    localparam logic [7:0] FRAC_MASK    = 8'h3F;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] RST_DIV      = 8'h01;
    // Arbitrary identity values
    localparam logic [7:0] REV_CODE_DEF = 8'h01;
    localparam logic [7:0] ID_CODE_DEF  = 8'h5A;
    localparam int         FIFO_DEPTH   = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } urm_bus_t;

    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic carrier_in_n;
        logic ring_in_n;
    } urm_modem_in_t;

    typedef enum logic [2:0] {
        BANK_NORMAL  = 3'b001,
        BANK_DIVISOR = 3'b010,
        BANK_ENH     = 3'b100
    } urm_bank_t;
endpackage

//--- core/urm_fifo.sv
/*
 * Small flop FIFO with valid/ready on both sides.
 * Assumes one clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module urm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rp_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wp_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- testbench/urm_channel_asserts.sv
/*
 * Concurrent checks on one register window channel.
 * Assumes the urm_channel ports and single-cycle host strobes.
 */
`timescale 1ns/1ps
module urm_chan_asserts
    import urm_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire urm_bus_t    bus,
    input wire logic [7:0]  rdata,
    input wire logic        tsr_out,
    input wire logic        rx_pin,
    input wire logic        tsr_in,
    input wire logic        tx_pin,
    input wire logic        rts_n,
    input wire logic        dtr_n,
    input wire logic [7:0]  ctl_line,
    input wire logic [7:0]  ctl_fifo,
    input wire logic [15:0] ctl_div,
    input wire logic [7:0]  ctl_frac
);
    // ------------------------------------------------------------
    // Shadow of loopback and extension bits
    // ------------------------------------------------------------
    logic loop_q;
    logic ext4_q;
    wire  line_std = ctl_line != LINE_UNLOCK;
    wire  div_acc  = ctl_line[LINE_DIV_BIT] && line_std;
    wire  wr_hit   = bus.wr && line_std;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loop_q <= 1'h0;
        end else if (wr_hit && bus.addr == OFS_MCTL) begin
            loop_q <= bus.wdata[MDM_LOOP_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext4_q <= 1'h0;
        end else if (bus.wr && bus.addr == OFS_ISTAT && !line_std) begin
            ext4_q <= bus.wdata[ENH_EXT_BIT];
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Pins are registered, so mode must hold two edges
    sequence s_loop_on;
        loop_q ##1 loop_q;
    endsequence
    sequence s_loop_off;
        !loop_q ##1 !loop_q;
    endsequence
    sequence s_frac_wr;
        bus.wr && bus.addr == OFS_ISTAT && div_acc;
    endsequence

    a_loop_pins_held: assert property (s_loop_on |-> tx_pin && rts_n && dtr_n)
        else $error("pins not held in loopback");
    a_loop_data_path: assert property (s_loop_on |-> tsr_in == $past(tsr_out))
        else $error("loopback path broken");
    a_normal_rx_path: assert property (s_loop_off |-> tsr_in == $past(rx_pin))
        else $error("receive pin not routed");
    a_line_write_taken: assert property (wr_hit && bus.addr == OFS_LCTL |=>
        ctl_line == $past(bus.wdata)) else $error("line control not loaded");
    a_div_low_write: assert property (bus.wr && bus.addr == OFS_HOLD && div_acc |=>
        ctl_div[7:0] == $past(bus.wdata)) else $error("divisor low not loaded");
    a_div_high_write: assert property (bus.wr && bus.addr == OFS_IEN && div_acc |=>
        ctl_div[15:8] == $past(bus.wdata)) else $error("divisor high not loaded");
    a_frac_open_write: assert property (s_frac_wr and ext4_q |=>
        ctl_frac == ($past(bus.wdata) & FRAC_MASK)) else $error("fraction not loaded");
    a_frac_locked: assert property (s_frac_wr and !ext4_q |=> $stable(ctl_frac))
        else $error("fraction written while locked");
    a_fifo_ext_gate: assert property (wr_hit && bus.addr == OFS_ISTAT && !ctl_line[7] |=>
        (ctl_fifo & 8'hF9) == ($past(bus.wdata) & ($past(ext4_q) ? 8'hF9 : 8'hC9)))
        else $error("fifo control bits wrong");
    a_rdata_holds: assert property (!bus.rd |=> $stable(rdata))
        else $error("read data moved without read");
endmodule

bind urm_channel urm_chan_asserts i_chk (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .tsr_out(tsr_out),
    .rx_pin(rx_pin), .tsr_in(tsr_in), .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n),
    .ctl_line(ctl_line), .ctl_fifo(ctl_fifo), .ctl_div(ctl_div), .ctl_frac(ctl_frac)
);

//--- testbench/urm_host_model.sv
/*
 * Host processor model: two active-low channel selects over one strobe bus.
 * Assumes channel read data is registered and valid after the taking edge.
 */
`timescale 1ns/1ps
module urm_host_model
    import urm_pkg::*;
(
    input  wire logic       clk,
    output urm_bus_t        bus_a,
    output urm_bus_t        bus_b,
    input  wire logic [7:0] rdata_a,
    input  wire logic [7:0] rdata_b
);
    logic     chan_a_select_n = 1'h1;
    logic     chan_b_select_n = 1'h1;
    urm_bus_t req             = '0;

    // Select low gates the strobes onto its own channel only
    always_comb begin
        bus_a = req;
        bus_b = req;
        bus_a.rd = req.rd && !chan_a_select_n;
        bus_a.wr = req.wr && !chan_a_select_n;
        bus_b.rd = req.rd && !chan_b_select_n;
        bus_b.wr = req.wr && !chan_b_select_n;
    end

    task automatic xfer(input logic ch_b, input logic wr, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        chan_a_select_n = ch_b;
        chan_b_select_n = !ch_b;
        req.rd = !wr;
        req.wr = wr;
        req.addr = a;
        req.wdata = d;
        @(posedge clk);
        #1;
        chan_a_select_n = 1'h1;
        chan_b_select_n = 1'h1;
        req.rd = 1'h0;
        req.wr = 1'h0;
        // Released lines do not keep the last value
        req.addr = ~a;
        req.wdata = ~d;
        q = ch_b ? rdata_b : rdata_a;
    endtask
endmodule

//--- testbench/tb.sv
/*
 * Self-checking bench for two register window channels.
 * Assumes the host model drives strobes and the bench the serial side.
 */
`timescale 1ns/1ps
module tb;
    import urm_pkg::*;
    logic          clk, rst_n, tx_valid, tx_ready, rx_valid, rx_ready;
    logic          tsr_out, rx_pin, tsr_in, tx_pin, rts_n, dtr_n, auto_rts_en, auto_cts_en;
    logic [7:0]    rdata_a, rdata_b, tx_data, rx_data, line_status, q;
    logic [7:0]    ctl_line, ctl_fifo, ctl_frac;
    bit            rx_seen;
    logic [15:0]   ctl_div;
    logic [5:0]    int_source;
    urm_bus_t      bus_a, bus_b;
    urm_modem_in_t modem_in;
    int            miscompares, n_checks, cycles;

    urm_host_model i_urm_host_model (.clk(clk), .bus_a(bus_a), .bus_b(bus_b),
        .rdata_a(rdata_a), .rdata_b(rdata_b));
    urm_channel i_urm_channel (.clk(clk), .rst_n(rst_n), .bus(bus_a), .rdata(rdata_a),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .line_status(line_status),
        .int_source(int_source), .tsr_out(tsr_out), .rx_pin(rx_pin), .tsr_in(tsr_in),
        .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n), .modem_in(modem_in),
        .ctl_line(ctl_line), .ctl_fifo(ctl_fifo), .ctl_div(ctl_div), .ctl_frac(ctl_frac),
        .auto_rts_en(auto_rts_en), .auto_cts_en(auto_cts_en));
    urm_channel i_urm_channel_b (.clk(clk), .rst_n(rst_n), .bus(bus_b), .rdata(rdata_b),
        .tx_valid(), .tx_ready(tx_ready), .tx_data(), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(), .line_status(line_status),
        .int_source(int_source), .tsr_out(tsr_out), .rx_pin(rx_pin), .tsr_in(),
        .tx_pin(), .rts_n(), .dtr_n(), .modem_in(modem_in), .ctl_line(), .ctl_fifo(),
        .ctl_div(), .ctl_frac(), .auto_rts_en(), .auto_cts_en());

    // ------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (rx_ready) rx_seen = 1'h1;
        // About 120 cycles expected; generous margin
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic w(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        i_urm_host_model.xfer(1'h0, 1'h1, a, d, dummy);
    endtask

    task automatic rc(input logic [2:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] v;
        i_urm_host_model.xfer(1'h0, 1'h0, a, 8'h00, v);
        chk(nm, v, exp);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, tx_ready, rx_valid} = 3'h0;
        rx_data = 8'h9E;
        line_status = 8'h61;
        int_source = 6'h3C;
        {tsr_out, rx_pin} = 2'h3;
        modem_in = 4'hF;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'h1;
        rc(OFS_LCTL, RST_BYTE, "lcr reset");
        chk("div reset", ctl_div, {RST_BYTE, RST_DIV});
        w(OFS_SCRATCH, 8'hA5);
        i_urm_host_model.xfer(1'h1, 1'h1, OFS_SCRATCH, 8'h3C, q);
        rc(OFS_SCRATCH, 8'hA5, "scratch a");
        i_urm_host_model.xfer(1'h1, 1'h0, OFS_SCRATCH, 8'h00, q);
        chk("scratch b", q, 8'h3C);
        w(OFS_LCTL, 8'h1B);
        rc(OFS_LCTL, 8'h1B, "lcr");
        w(OFS_IEN, 8'hFF);
        rc(OFS_IEN, 8'h0F, "ier locked");
        w(OFS_LCTL, 8'h80);
        w(OFS_HOLD, 8'h34);
        w(OFS_IEN, 8'h12);
        rc(OFS_HOLD, 8'h34, "div low");
        rc(OFS_IEN, 8'h12, "div high");
        w(OFS_ISTAT, 8'h3F);
        chk("frac locked", ctl_frac, RST_BYTE);
        w(OFS_HOLD, 8'h00);
        w(OFS_IEN, 8'h00);
        rc(OFS_HOLD, REV_CODE_DEF, "revision");
        rc(OFS_IEN, ID_CODE_DEF, "ident");
        w(OFS_LCTL, LINE_UNLOCK);
        w(OFS_ISTAT, 8'hD0);
        for (int i = 4; i < 8; i++) w(3'(i), 8'(i * 17));
        for (int i = 4; i < 8; i++) rc(3'(i), 8'(i * 17), "enhanced");
        rc(OFS_ISTAT, 8'hD0, "efr");
        chk("auto flow", {auto_rts_en, auto_cts_en}, 2'h3);
        w(OFS_LCTL, 8'h80);
        rc(OFS_ISTAT, RST_BYTE, "frac kept");
        w(OFS_ISTAT, 8'hEA);
        rc(OFS_ISTAT, 8'h2A, "frac");
        w(OFS_LCTL, 8'h00);
        rc(OFS_SCRATCH, 8'hA5, "scratch kept");
        w(OFS_IEN, 8'hFF);
        rc(OFS_IEN, 8'hFF, "ier open");
        w(OFS_ISTAT, 8'hF9);
        chk("fcr", ctl_fifo & 8'hF9, 8'hF9);
        rc(OFS_ISTAT, 8'hFC, "isr");
        rc(OFS_LSTAT, 8'h61, "lsr");
        // Fifth write must be dropped while the far side stalls
        for (int i = 0; i < 5; i++) w(OFS_HOLD, 8'h50 + 8'(i));
        tx_ready = 1'h1;
        for (int i = 0; i < 4; i++) begin
            chk("tx word", {tx_valid, tx_data}, {1'h1, 8'h50 + 8'(i)});
            @(posedge clk);
            #1;
        end
        chk("tx empty", tx_valid, 1'h0);
        tx_ready = 1'h0;
        rx_valid = 1'h1;
        rc(OFS_HOLD, 8'h9E, "rhr");
        rx_valid = 1'h0;
        chk("rx ack", rx_seen, 1'h1);
        w(OFS_MCTL, 8'h1F);
        rc(OFS_MCTL, 8'h1F, "mcr");
        chk("held pins", {tx_pin, rts_n, dtr_n}, 3'h7);
        chk("auto off", {auto_rts_en, auto_cts_en}, 2'h0);
        tsr_out = 1'h0;
        @(posedge clk);
        #1;
        chk("loop data", tsr_in, 1'h0);
        i_urm_host_model.xfer(1'h0, 1'h0, OFS_MSTAT, 8'h00, q);
        modem_in = 4'h0;
        rc(OFS_MSTAT, 8'hF0, "msr loop");
        w(OFS_MCTL, 8'h00);
        @(posedge clk);
        #1;
        chk("loop exit", tsr_in, 1'h1);
        conclude();
    end
endmodule
